// *** common/ium_defs.svh ***
`ifndef IUM_DEFS_SVH
`define IUM_DEFS_SVH
`define IUM_OFS_MASK_LOW    8'h40
`define IUM_OFS_MASK_MID    8'h44
`define IUM_OFS_MASK_HIGH   8'h48
`define IUM_OFS_UNMASK_LOW  8'h60
`define IUM_OFS_UNMASK_MID  8'h64
`define IUM_OFS_UNMASK_HIGH 8'h68
`define IUM_OFS_MODE        8'h80
`define IUM_OFS_IRQ_STATUS  8'h90
`define IUM_OFS_IRQ_ENABLE  8'h94
`define IUM_MODE_FLAG_BIT   0
`define IUM_MASK_RESET      1'b1
`define IUM_MODE_RESET      1'b0
`define IUM_CODE_TOP_BIT    11
`define IUM_NUM_INTS        96
`define IUM_RESP_OKAY       2'b00
`define IUM_RESP_SLVERR     2'b10
`endif

// *** common/ium_pkg.sv ***
package ium_pkg;
   typedef struct packed {
      logic [11:0] code;
      logic        valid;
   } ium_event_t;
endpackage

// *** logic/ium_code_remap.sv ***
`timescale 1ns/1ps
`include "ium_defs.svh"
// ----------------------------------------------------------------------
// Event code remap
// ----------------------------------------------------------------------
module ium_code_remap (
   input  wire logic              aclk,      // Clock.
   input  wire logic              aresetn,   // Synchronous reset, low.
   input  wire logic              remap_en,  // Remap flag.
   input  wire ium_pkg::ium_event_t evt_in,  // Code from priority logic.
   output      ium_pkg::ium_event_t evt_out  // Code toward the core.
);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         evt_out <= '0;
      end else begin
         evt_out <= evt_in;
         if (remap_en) begin
            evt_out.code[`IUM_CODE_TOP_BIT] <= 1'b0;
         end
      end
   end

   AST_REMAP: assert property (@(posedge aclk) disable iff (!aresetn)
      ##1 $past(remap_en) && $past(evt_in.valid) |->
      evt_out.code == ($past(evt_in.code) & 12'h7ff))
      else $error("remap of top code bit wrong");
   AST_PASS: assert property (@(posedge aclk) disable iff (!aresetn)
      ##1 !$past(remap_en) |-> evt_out == $past(evt_in))
      else $error("code not passed unchanged");
endmodule

// *** logic/ium_unmask_remap.sv ***
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "ium_defs.svh"
// Notes on behaviour
// - Three write-only 32-bit unmask words at 0x60, 0x64, 0x68.
// - Writing one to an unmask bit clears its mask; zero leaves it.
// - Masks clear only via unmask words; mask words read and set.
// - Up to 96 interrupts; unused bits read zero, writes ignored.
// - A 32-bit read-write mode register holds the remap flag.
// - Flag set turns code 0xa00 into 0x200; clear passes unchanged.
// - Flag is bit 0 at 0x80, resets to 0, clears top code bit.
// - Mask words at 0x40, 0x44, 0x48 read back; one sets; reset all ones.
module ium_unmask_remap #(
   parameter int NUM_INTS = `IUM_NUM_INTS
) (
   input  wire logic               aclk,          // Clock, 10 MHz.
   input  wire logic               aresetn,       // Synchronous reset, low.
   input  wire logic [7:0]         s_axi_awaddr,  // Write address.
   input  wire logic               s_axi_awvalid, // Write address valid.
   output      logic               s_axi_awready, // Write address ready.
   input  wire logic [31:0]        s_axi_wdata,   // Write data.
   input  wire logic [3:0]         s_axi_wstrb,   // Write byte strobes.
   input  wire logic               s_axi_wvalid,  // Write data valid.
   output      logic               s_axi_wready,  // Write data ready.
   output      logic [1:0]         s_axi_bresp,   // Write response.
   output      logic               s_axi_bvalid,  // Write response valid.
   input  wire logic               s_axi_bready,  // Write response ready.
   input  wire logic [7:0]         s_axi_araddr,  // Read address.
   input  wire logic               s_axi_arvalid, // Read address valid.
   output      logic               s_axi_arready, // Read address ready.
   output      logic [31:0]        s_axi_rdata,   // Read data.
   output      logic [1:0]         s_axi_rresp,   // Read response.
   output      logic               s_axi_rvalid,  // Read data valid.
   input  wire logic               s_axi_rready,  // Read data ready.
   input  wire logic [95:0]        irq_req,       // Module requests, same clock.
   input  wire ium_pkg::ium_event_t evt_in,       // Selected code, same clock.
   output      logic [95:0]        irq_fwd,       // Requests to priority logic.
   output      logic [95:0]        mask_bits,     // Current mask vector.
   output      ium_pkg::ium_event_t evt_out,      // Code to the core.
   output      logic               irq           // Interrupt, level, high.
);
   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   localparam logic [95:0] IMPL = (NUM_INTS >= 96) ? {96{1'b1}} :
                                  ((96'h1 << NUM_INTS) - 96'h1);

   function automatic logic [31:0] strb_mask(input logic [3:0] s);
      strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
   endfunction

   function automatic logic [95:0] word_place(input logic [31:0] v,
                                              input logic [1:0]  idx);
      logic [95:0] r;
      r = '0;
      r[idx*32 +: 32] = v;
      word_place = r;
   endfunction

   // ----------------------------------------------------------------------
   // Write channel
   // ----------------------------------------------------------------------
   logic        aw_held_q;
   logic [7:0]  aw_addr_q;
   logic        w_held_q;
   logic [31:0] w_data_q;
   logic [3:0]  w_strb_q;
   logic        wr_fire;
   logic [31:0] wr_bits;
   logic        wr_mapped;
   logic [95:0] set_vec;
   logic [95:0] clr_vec;
   logic        mode_flag_q;
   logic [1:0]  irq_stat_q;
   logic [1:0]  irq_en_q;
   logic [1:0]  irq_stat_clr;

   // Both halves are held until the write fires and no new half is taken until the response is, so only one write is in
   // flight and a second address can never pair with the data of the first.
   assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;
   assign wr_bits = w_data_q & strb_mask(w_strb_q);

   always_comb begin
      set_vec      = '0;
      clr_vec      = '0;
      irq_stat_clr = '0;
      wr_mapped    = 1'b1;
      unique case (aw_addr_q)
         `IUM_OFS_MASK_LOW:    set_vec = word_place(wr_bits, 2'd0);
         `IUM_OFS_MASK_MID:    set_vec = word_place(wr_bits, 2'd1);
         `IUM_OFS_MASK_HIGH:   set_vec = word_place(wr_bits, 2'd2);
         `IUM_OFS_UNMASK_LOW:  clr_vec = word_place(wr_bits, 2'd0);
         `IUM_OFS_UNMASK_MID:  clr_vec = word_place(wr_bits, 2'd1);
         `IUM_OFS_UNMASK_HIGH: clr_vec = word_place(wr_bits, 2'd2);
         `IUM_OFS_MODE:        wr_mapped = 1'b1;
         `IUM_OFS_IRQ_STATUS:  irq_stat_clr = wr_bits[1:0];
         `IUM_OFS_IRQ_ENABLE:  wr_mapped = 1'b1;
         default:              wr_mapped = 1'b0;
      endcase
      if (!wr_fire) begin
         set_vec      = '0;
         clr_vec      = '0;
         irq_stat_clr = '0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q <= 1'b0;
         aw_addr_q <= 8'h00;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held_q <= 1'b1;
         aw_addr_q <= {s_axi_awaddr[7:2], 2'b00};
      end else if (wr_fire) begin
         aw_held_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_q <= 1'b0;
         w_data_q <= 32'h0;
         w_strb_q <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held_q <= 1'b1;
         w_data_q <= s_axi_wdata;
         w_strb_q <= s_axi_wstrb;
      end else if (wr_fire) begin
         w_held_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end else begin
         s_axi_awready <= !aw_held_q && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
         s_axi_wready  <= !w_held_q && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `IUM_RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_mapped ? `IUM_RESP_OKAY : `IUM_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // Mask, mode and interrupt registers
   // ----------------------------------------------------------------------
   // A set and an unmask of the same bit cannot meet: each write hits one word.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mask_bits <= {96{`IUM_MASK_RESET}} & IMPL;
      end else begin
         mask_bits <= ((mask_bits & ~clr_vec) | set_vec) & IMPL;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_flag_q <= `IUM_MODE_RESET;
      end else if (wr_fire && aw_addr_q == `IUM_OFS_MODE && w_strb_q[0]) begin
         mode_flag_q <= w_data_q[`IUM_MODE_FLAG_BIT];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_en_q <= 2'b00;
      end else if (wr_fire && aw_addr_q == `IUM_OFS_IRQ_ENABLE && w_strb_q[0]) begin
         irq_en_q <= w_data_q[1:0];
      end
   end

   // Bit 0: a forwarded request is pending. Bit 1: a code reached the core.
   logic [1:0] irq_evt;
   assign irq_evt = {evt_out.valid, |irq_fwd};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_stat_q <= 2'b00;
         irq        <= 1'b0;
      end else begin
         irq_stat_q <= (irq_stat_q & ~irq_stat_clr) | irq_evt;
         irq        <= |(((irq_stat_q & ~irq_stat_clr) | irq_evt) & irq_en_q);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_fwd <= '0;
      end else begin
         irq_fwd <= irq_req & ~mask_bits & IMPL;
      end
   end

   ium_code_remap u_remap (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .remap_en (mode_flag_q),
      .evt_in   (evt_in),
      .evt_out  (evt_out)
   );

   // ----------------------------------------------------------------------
   // Read channel
   // ----------------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0;
         s_axi_rresp  <= `IUM_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= `IUM_RESP_OKAY;
         unique case ({s_axi_araddr[7:2], 2'b00})
            `IUM_OFS_MASK_LOW:    s_axi_rdata <= mask_bits[31:0];
            `IUM_OFS_MASK_MID:    s_axi_rdata <= mask_bits[63:32];
            `IUM_OFS_MASK_HIGH:   s_axi_rdata <= mask_bits[95:64];
            // Unmask words read as zero so they are never taken for the live mask.
            `IUM_OFS_UNMASK_LOW,
            `IUM_OFS_UNMASK_MID,
            `IUM_OFS_UNMASK_HIGH: s_axi_rdata <= 32'h0;
            `IUM_OFS_MODE:        s_axi_rdata <= {31'h0, mode_flag_q};
            `IUM_OFS_IRQ_STATUS:  s_axi_rdata <= {30'h0, irq_stat_q};
            `IUM_OFS_IRQ_ENABLE:  s_axi_rdata <= {30'h0, irq_en_q};
            default: begin
               s_axi_rdata <= 32'h0;
               s_axi_rresp <= `IUM_RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   AST_UNMASK_CLEARS: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_fire && aw_addr_q == `IUM_OFS_UNMASK_LOW |=>
      (mask_bits[31:0] & $past(wr_bits)) == 32'h0)
      else $error("unmask write left mask bit set");
   AST_UNMASK_ZERO_KEEPS: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_fire && aw_addr_q == `IUM_OFS_UNMASK_MID |=>
      (mask_bits[63:32] | $past(wr_bits)) == ($past(mask_bits[63:32]) | $past(wr_bits)))
      else $error("unmask write disturbed other bits");
   AST_ONLY_UNMASK_CLEARS: assert property (@(posedge aclk) disable iff (!aresetn)
      $fell(mask_bits[0]) |-> $past(aw_addr_q) == `IUM_OFS_UNMASK_LOW && $past(wr_fire))
      else $error("mask bit cleared without unmask write");
   AST_MASK_SETS: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_fire && aw_addr_q == `IUM_OFS_MASK_HIGH |=>
      (mask_bits[95:64] & $past(wr_bits & IMPL[95:64])) == $past(wr_bits & IMPL[95:64]))
      else $error("mask write did not set bits");
   AST_UNUSED_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
      (mask_bits & ~IMPL) == 96'h0)
      else $error("unimplemented mask bit set");
   AST_MODE_WRITE: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_fire && aw_addr_q == `IUM_OFS_MODE && w_strb_q[0] |=>
      mode_flag_q == $past(w_data_q[0]))
      else $error("mode flag not written");
   AST_FORWARD: assert property (@(posedge aclk) disable iff (!aresetn)
      ##1 irq_fwd == ($past(irq_req) & ~$past(mask_bits) & IMPL))
      else $error("forwarding ignores mask");
   AST_WO_READ: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_arvalid && s_axi_arready && s_axi_araddr == `IUM_OFS_UNMASK_LOW |=>
      s_axi_rvalid && s_axi_rdata == 32'h0)
      else $error("unmask word read not zero");

   // ----------------------------------------------------------------------
   // Reset, read-back, write, forwarding and interrupt checks
   // ----------------------------------------------------------------------
   AST_MASK_RESET: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(aresetn) |->
      mask_bits == IMPL)
      else $error("mask not all ones after reset");
   AST_MODE_RESET: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(aresetn) |->
      !mode_flag_q)
      else $error("mode flag not clear after reset");
   AST_FWD_RESET: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(aresetn) |->
      irq_fwd == 96'h0 && !evt_out.valid)
      else $error("request forwarded out of reset");
   AST_MASK_READ: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_arvalid && s_axi_arready && {s_axi_araddr[7:2], 2'b00} == `IUM_OFS_MASK_MID |=>
      s_axi_rdata == $past(mask_bits[63:32]))
      else $error("mask word read back wrong");
   AST_MODE_READ: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_arvalid && s_axi_arready && {s_axi_araddr[7:2], 2'b00} == `IUM_OFS_MODE |=>
      s_axi_rdata == {31'h0, $past(mode_flag_q)})
      else $error("mode register read back wrong");
   AST_UNMASK_NO_SET: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_fire && aw_addr_q == `IUM_OFS_UNMASK_HIGH |=>
      (mask_bits & ~$past(mask_bits)) == 96'h0)
      else $error("unmask write set a mask bit");
   AST_SET_NO_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_fire && aw_addr_q == `IUM_OFS_MASK_LOW |=>
      ($past(mask_bits) & ~mask_bits) == 96'h0)
      else $error("mask write cleared a mask bit");
   AST_UNMASK_OKAY: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_fire && aw_addr_q == `IUM_OFS_UNMASK_MID |=>
      s_axi_bvalid && s_axi_bresp == `IUM_RESP_OKAY)
      else $error("unmask write not answered okay");
   AST_MODE_ONLY_WRITE: assert property (@(posedge aclk) disable iff (!aresetn)
      !(wr_fire && aw_addr_q == `IUM_OFS_MODE) |=>
      $stable(mode_flag_q))
      else $error("mode flag changed without a write");
   AST_MASK_ONLY_BUS: assert property (@(posedge aclk) disable iff (!aresetn)
      !wr_fire |=>
      $stable(mask_bits))
      else $error("mask changed without a write");
   AST_FWD_UNMASKED: assert property (@(posedge aclk) disable iff (!aresetn)
      (irq_fwd & $past(mask_bits)) == 96'h0)
      else $error("masked request forwarded");
   AST_IRQ_LEVEL: assert property (@(posedge aclk) disable iff (!aresetn)
      irq == |(irq_stat_q & $past(irq_en_q)))
      else $error("interrupt level disagrees with status");
   AST_STATUS_STICKY: assert property (@(posedge aclk) disable iff (!aresetn)
      irq_stat_q[1] && !irq_stat_clr[1] |=>
      irq_stat_q[1])
      else $error("status bit dropped without a clear");
   COV_UNMASK: cover property (@(posedge aclk) wr_fire && aw_addr_q == `IUM_OFS_UNMASK_HIGH);
   COV_MASK_SET: cover property (@(posedge aclk) wr_fire && aw_addr_q == `IUM_OFS_MASK_LOW);
   COV_STATUS_CLEAR: cover property (@(posedge aclk) |irq_stat_clr);
   COV_REMAP: cover property (@(posedge aclk) mode_flag_q && evt_in.valid);
   COV_FWD: cover property (@(posedge aclk) |irq_fwd);
endmodule

// *** dv/ium_core_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Core side: takes every code handed over
// ----------------------------------------------------------------------
module ium_core_model (
   input wire logic                aclk,    // Clock.
   input wire logic                aresetn, // Synchronous reset, low.
   input wire ium_pkg::ium_event_t evt      // Code from the block.
);
   logic [11:0] got_q [$];
   // The core has no way to stall a code, so it must take one every valid cycle.
   always @(posedge aclk) begin
      if (aresetn === 1'b1 && evt.valid === 1'b1) begin
         got_q.push_back(evt.code);
      end
   end
endmodule

// *** dv/tb_interrupt_unmask_and_code_remap.sv ***
`timescale 1ns/1ps
`include "ium_defs.svh"
module tb_interrupt_unmask_and_code_remap;
   logic                aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic                awready, wready, bvalid, arready, rvalid, irq;
   logic [7:0]          awaddr, araddr;
   logic [31:0]         wdata, rdata, rv, v;
   logic [3:0]          wstrb;
   logic [1:0]          bresp, rresp, rs;
   logic [95:0]         irq_req, irq_fwd, mask_bits, m_mask;
   logic [11:0]         c;
   ium_pkg::ium_event_t evt_in, evt_out;
   int                  err_total, compares, seed, cyc;
   logic [11:0]         exp_q [$];

   ium_unmask_remap ium_unmask_remap_i (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq_req(irq_req),
      .evt_in(evt_in), .irq_fwd(irq_fwd), .mask_bits(mask_bits),
      .evt_out(evt_out), .irq(irq));
   ium_core_model core_i (.aclk(aclk), .aresetn(aresetn), .evt(evt_out));

   initial begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end

   task automatic close_out();
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // A hang in a handshake wait would otherwise stall the run for ever.
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         close_out();
      end
   end

   task automatic check(input logic [95:0] got, input logic [95:0] exp, input string m);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                     output logic [1:0] r);
      bit ad;
      bit wd;
      ad = 0;
      wd = 0;
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= d;
      wstrb   <= s;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      while (!(ad && wd)) begin
         @(posedge aclk);
         if (awvalid && awready === 1'b1) begin
            ad = 1;
            awvalid <= 1'b0;
         end
         if (wvalid && wready === 1'b1) begin
            wd = 1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      while (rvalid !== 1'b1) @(posedge aclk);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask

   initial begin
      seed = 19;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata, wstrb} = '0;
      irq_req = '0;
      evt_in = '0;
      aresetn = 1'b0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      m_mask = '1;
      for (int i = 0; i < 3; i++) begin
         rd(8'h40 + 8'(4 * i), rv, rs);
         check(rv, m_mask[32 * i +: 32], "mask reset");
         rd(8'h60 + 8'(4 * i), rv, rs);
         check(rv, 0, "unmask word read");
      end
      rd(`IUM_OFS_MODE, rv, rs);
      check(rv, 0, "mode reset");
      rd(8'h10, rv, rs);
      check(rs, `IUM_RESP_SLVERR, "unmapped read");
      $display("test reset done");
      for (int i = 0; i < 3; i++) begin
         for (int k = 0; k < 4; k++) begin
            v = $random(seed);
            wr(`IUM_OFS_UNMASK_LOW + 8'(4 * i), v, 4'hf, rs);
            check(rs, `IUM_RESP_OKAY, "unmask resp");
            m_mask[32 * i +: 32] &= ~v;
            rd(`IUM_OFS_MASK_LOW + 8'(4 * i), rv, rs);
            check(rv, m_mask[32 * i +: 32], "unmask effect");
         end
         v = $random(seed);
         wr(`IUM_OFS_MASK_LOW + 8'(4 * i), v, 4'h1, rs);
         m_mask[32 * i +: 8] |= v[7:0];
         rd(`IUM_OFS_MASK_LOW + 8'(4 * i), rv, rs);
         check(rv, m_mask[32 * i +: 32], "mask set, zeros ignored");
      end
      check(mask_bits, m_mask, "mask vector");
      wr(8'h10, 32'hffffffff, 4'hf, rs);
      check(rs, `IUM_RESP_SLVERR, "unmapped write");
      check(mask_bits, m_mask, "mask after unmapped write");
      $display("test unmask done");
      for (int k = 0; k < 8; k++) begin
         irq_req <= {$random(seed), $random(seed), $random(seed)};
         repeat (3) @(posedge aclk);
         check(irq_fwd, irq_req & ~m_mask, "forwarded requests");
      end
      $display("test forward done");
      for (int f = 0; f < 2; f++) begin
         wr(`IUM_OFS_MODE, f ? 32'hffffffff : 32'h00000000, 4'hf, rs);
         rd(`IUM_OFS_MODE, rv, rs);
         check(rv, f, "mode readback");
         for (int k = 0; k < 4; k++) begin
            c = (k == 0) ? 12'ha00 : (k == 1) ? 12'h200 : (k == 2) ? 12'hfff : 12'($random(seed));
            @(posedge aclk);
            evt_in <= '{code: c, valid: 1'b1};
            exp_q.push_back(f ? (c & 12'h7ff) : c);
            @(posedge aclk);
            evt_in <= '0;
         end
         repeat (3) @(posedge aclk);
         check(core_i.got_q.size(), exp_q.size(), "code count");
         while (exp_q.size() > 0 && core_i.got_q.size() > 0) begin
            check(core_i.got_q.pop_front(), exp_q.pop_front(), "event code");
         end
      end
      $display("test remap done");
      wr(`IUM_OFS_UNMASK_LOW, 32'hffffffff, 4'hf, rs);
      wr(`IUM_OFS_IRQ_ENABLE, 32'h00000001, 4'hf, rs);
      irq_req <= '1;
      repeat (3) @(posedge aclk);
      check(irq, 1'b1, "irq raised");
      rd(`IUM_OFS_IRQ_STATUS, rv, rs);
      check(rv[0], 1'b1, "status pending");
      wr(`IUM_OFS_IRQ_ENABLE, 32'h00000000, 4'hf, rs);
      @(posedge aclk);
      check(irq, 1'b0, "irq masked");
      irq_req <= '0;
      repeat (3) @(posedge aclk);
      wr(`IUM_OFS_IRQ_STATUS, 32'h00000003, 4'hf, rs);
      rd(`IUM_OFS_IRQ_STATUS, rv, rs);
      check(rv, 0, "status cleared");
      wr(`IUM_OFS_IRQ_ENABLE, 32'h00000003, 4'hf, rs);
      repeat (3) @(posedge aclk);
      check(irq, 1'b0, "irq stays low");
      $display("test interrupt done");
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      m_mask = '1;
      rd(`IUM_OFS_MASK_MID, rv, rs);
      check(rv, m_mask[63:32], "mask after second reset");
      rd(`IUM_OFS_MODE, rv, rs);
      check(rv, 0, "mode after second reset");
      check(irq, 1'b0, "irq after second reset");
      check(irq_fwd, 0, "forwarding after second reset");
      $display("test second reset done");
      close_out();
   end
endmodule
